// ===== baud_counter.v
/*
 Baud-period down counter with a programmable reload value.
 Assumes the reload value is stable while the counter runs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2c_rx_consts.vh"

module baud_counter (
  // Clock and reset
  input  wire       clk,
  input  wire       rstn,
  // Control
  input  wire       go,
  input  wire [7:0] reload,
  // Rollover pulse
  output wire       tick
);

  reg [7:0] count_q;

  // Held at the reload value while stopped, so each start gives a full period
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= `RST_BAUD;
    end else if (!go || count_q == 8'h00) begin
      count_q <= reload;
    end else begin
      count_q <= count_q - 8'h01;
    end
  end

  assign tick = go && (count_q == 8'h00);

endmodule
`default_nettype wire

// ===== i2c_master_rx_ack_stop.v
/*
 Two-wire bus controller: master start, address send, byte receive,
 acknowledge and stop sequencing, plus software clock hold.
 Assumes open-drain bus lines resolved outside, a plain register port
 driven by logic on clk, and software that sequences the requests.
*/
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_rx_consts.vh"

// Notes on behaviour
// - Clock hold grabs SCL only once seen low
// - Held SCL stays low until hold released
// - Receive request ignored unless module idle
// - Each baud rollover toggles SCL; those that pull SCL low shift SDA
// - Eighth falling edge ends byte, buffer loaded
// - Byte into buffer sets buffer full
// - Reading buffer clears buffer full
// - Byte while buffer full sets overflow
// - Buffer write during receive flags collision
// - Acknowledge drives SCL low, ack data on SDA
// - Ack: one period low, release, one period high
// - Ack end clears request, stops baud, idles
// - Buffer write during acknowledge flags collision
// - SCL held low after ninth falling edge
// - Stop drives SDA low, then counts period
// - Stop releases SCL, SDA one period later
// - Stop seen sets flag, later interrupt flag
// - Buffer write during stop flags collision
// - Buffer write in idle sends address byte
// - Ninth clock samples acknowledge, sets interrupt
// - Completed start sets interrupt flag
// - Setting clock hold bit releases SCL
module i2c_master_rx_ack_stop (
  // Clock and reset
  input  wire       clk,
  input  wire       rstn,
  // Register port
  input  wire [2:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdata,
  // Clock line
  input  wire       sclIn,
  output reg        sclOut,
  output reg        sclOe,
  // Data line
  input  wire       sdaIn,
  output reg        sdaOut,
  output reg        sdaOe,
  // Event flag
  output reg        serialIrq
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_TX    = 3'h2;
  localparam [2:0] ST_RX    = 3'h3;
  localparam [2:0] ST_ACK   = 3'h4;
  localparam [2:0] ST_STOP  = 3'h5;

  reg [2:0] state_q;
  reg [1:0] phase_q;
  reg [3:0] bitCnt_q;
  reg [7:0] shift_q;
  reg [7:0] buffer_q;
  reg [7:0] baudReload_q;
  reg       clockHold_q;
  reg       write_collision_flag_q;
  reg       overflow_q;
  reg       startReq_q;
  reg       stopReq_q;
  reg       rcvReq_q;
  reg       ackReq_q;
  reg       ackData_q;
  reg       ackRecv_q;
  reg       bufFull_q;
  reg       stopDet_q;
  reg       irq_q;
  reg       sclLow_q;
  reg       sdaLow_q;
  reg       holdLow_q;
  reg       brgGo;

  wire      sclSync;
  wire      sdaSync;
  wire      tick;
  wire      idle;
  wire      anyReq;

  function hit;
    input [2:0] addr;
    input [2:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  pin_sync u_sync (
    .clk     (clk),
    .rstn    (rstn),
    .sclPin  (sclIn),
    .sdaPin  (sdaIn),
    .sclSync (sclSync),
    .sdaSync (sdaSync)
  );

  baud_counter u_baud (
    .clk    (clk),
    .rstn   (rstn),
    .go     (brgGo),
    .reload (baudReload_q),
    .tick   (tick)
  );

  assign idle   = (state_q == ST_IDLE);
  assign anyReq = startReq_q | stopReq_q | rcvReq_q | ackReq_q;

  // Baud counting pauses while a released SCL is still held low elsewhere
  always @* begin
    brgGo = 1'b0;
    case (state_q)
      ST_START: begin
        brgGo = (phase_q == 2'h0) ? (sclSync && sdaSync) : 1'b1;
      end
      ST_TX, ST_RX: begin
        brgGo = sclLow_q | sclSync;
      end
      ST_ACK: begin
        brgGo = (phase_q == 2'h0) ? 1'b1 : sclSync;
      end
      ST_STOP: begin
        case (phase_q)
          2'h0:    brgGo = !sdaSync;
          2'h1:    brgGo = sclSync;
          2'h2:    brgGo = 1'b0;
          default: brgGo = 1'b1;
        endcase
      end
      default: begin
        brgGo = 1'b0;
      end
    endcase
  end

  // Registers, request handling and sequencing share one process
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= ST_IDLE;
      phase_q      <= 2'h0;
      bitCnt_q     <= 4'h0;
      shift_q      <= 8'h00;
      buffer_q     <= 8'h00;
      baudReload_q <= `RST_BAUD;
      clockHold_q  <= `RST_CLK_HOLD;
      write_collision_flag_q       <= 1'b0;
      overflow_q   <= 1'b0;
      startReq_q   <= 1'b0;
      stopReq_q    <= 1'b0;
      rcvReq_q     <= 1'b0;
      ackReq_q     <= 1'b0;
      ackData_q    <= 1'b0;
      ackRecv_q    <= 1'b0;
      bufFull_q    <= 1'b0;
      stopDet_q    <= 1'b0;
      irq_q        <= 1'b0;
      sclLow_q     <= 1'b0;
      sdaLow_q     <= 1'b0;
    end else begin
      // Software writes; flags only clear by writing zero
      if (regWr && hit(regAddr, `OFF_CTRL_ONE)) begin
        clockHold_q <= regWdata[`BIT_CLK_HOLD];
        write_collision_flag_q      <= write_collision_flag_q & regWdata[`BIT_WRITE_COLLISION_FLAG];
        overflow_q  <= overflow_q & regWdata[`BIT_OVERFLOW];
      end
      if (regWr && hit(regAddr, `OFF_CTRL_TWO)) begin
        ackData_q <= regWdata[`BIT_ACK_DATA];
        if (idle && !anyReq) begin
          startReq_q <= regWdata[`BIT_START_REQ];
          stopReq_q  <= regWdata[`BIT_STOP_REQ];
          rcvReq_q   <= regWdata[`BIT_RCV_REQ];
          ackReq_q   <= regWdata[`BIT_ACK_REQ];
        end
      end
      if (regWr && hit(regAddr, `OFF_BAUD)) begin
        baudReload_q <= regWdata;
      end
      if (regWr && hit(regAddr, `OFF_IRQ)) begin
        irq_q <= irq_q & regWdata[`BIT_IRQ];
      end
      if (regRd && hit(regAddr, `OFF_BUFFER)) begin
        bufFull_q <= 1'b0;
      end
      // A busy module keeps its buffer
      if (regWr && hit(regAddr, `OFF_BUFFER) && (!idle || anyReq)) begin
        write_collision_flag_q <= 1'b1;
      end

      // Sequencing; hardware sets come last so they win over clears
      case (state_q)
        ST_IDLE: begin
          phase_q  <= 2'h0;
          bitCnt_q <= 4'h0;
          if (startReq_q) begin
            state_q   <= ST_START;
            sclLow_q  <= 1'b0;
            sdaLow_q  <= 1'b0;
            stopDet_q <= 1'b0;
          end else if (stopReq_q) begin
            state_q  <= ST_STOP;
            sdaLow_q <= 1'b1;
          end else if (rcvReq_q) begin
            state_q  <= ST_RX;
            sclLow_q <= 1'b1;
            sdaLow_q <= 1'b0;
          end else if (ackReq_q) begin
            state_q  <= ST_ACK;
            sclLow_q <= 1'b1;
            sdaLow_q <= !ackData_q;
          end else if (regWr && hit(regAddr, `OFF_BUFFER)) begin
            state_q  <= ST_TX;
            buffer_q <= regWdata;
            shift_q  <= regWdata;
            sclLow_q <= 1'b1;
            sdaLow_q <= !regWdata[7];
          end
        end
        ST_START: begin
          if (tick) begin
            if (phase_q == 2'h0) begin
              sdaLow_q <= 1'b1;
              phase_q  <= 2'h1;
            end else begin
              sclLow_q   <= 1'b1;
              startReq_q <= 1'b0;
              irq_q      <= 1'b1;
              state_q    <= ST_IDLE;
            end
          end
        end
        ST_TX: begin
          if (tick) begin
            if (sclLow_q) begin
              sclLow_q <= 1'b0;
            end else if (bitCnt_q == `ACK_BIT_INDEX) begin
              ackRecv_q <= sdaSync;
              sclLow_q  <= 1'b1;
              irq_q     <= 1'b1;
              state_q   <= ST_IDLE;
            end else begin
              sclLow_q <= 1'b1;
              shift_q  <= {shift_q[6:0], 1'b0};
              sdaLow_q <= (bitCnt_q == `LAST_RX_BIT) ? 1'b0 : !shift_q[6];
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        ST_RX: begin
          if (tick) begin
            if (sclLow_q) begin
              sclLow_q <= 1'b0;
            end else begin
              sclLow_q <= 1'b1;
              shift_q  <= {shift_q[6:0], sdaSync};
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == `LAST_RX_BIT) begin
                rcvReq_q  <= 1'b0;
                buffer_q  <= {shift_q[6:0], sdaSync};
                bufFull_q <= 1'b1;
                irq_q     <= 1'b1;
                state_q   <= ST_IDLE;
                if (bufFull_q) begin
                  overflow_q <= 1'b1;
                end
              end
            end
          end
        end
        ST_ACK: begin
          if (tick) begin
            if (phase_q == 2'h0) begin
              sclLow_q <= 1'b0;
              phase_q  <= 2'h1;
            end else begin
              sclLow_q <= 1'b1;
              ackReq_q <= 1'b0;
              irq_q    <= 1'b1;
              state_q  <= ST_IDLE;
            end
          end
        end
        ST_STOP: begin
          case (phase_q)
            2'h0: begin
              if (tick) begin
                sclLow_q <= 1'b0;
                phase_q  <= 2'h1;
              end
            end
            2'h1: begin
              if (tick) begin
                sdaLow_q <= 1'b0;
                phase_q  <= 2'h2;
              end
            end
            2'h2: begin
              if (sdaSync && sclSync) begin
                stopDet_q <= 1'b1;
                phase_q   <= 2'h3;
              end
            end
            default: begin
              if (tick) begin
                stopReq_q <= 1'b0;
                irq_q     <= 1'b1;
                state_q   <= ST_IDLE;
              end
            end
          endcase
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Clock hold waits for SCL low so it never shortens a high phase
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      holdLow_q <= 1'b0;
    end else if (clockHold_q) begin
      holdLow_q <= 1'b0;
    end else if (!sclSync) begin
      holdLow_q <= 1'b1;
    end
  end

  // Registered pins and read data
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclOut    <= 1'b0;
      sclOe     <= 1'b0;
      sdaOut    <= 1'b0;
      sdaOe     <= 1'b0;
      serialIrq <= 1'b0;
      regRdata  <= 8'h00;
    end else begin
      sclOut    <= 1'b0;
      sclOe     <= sclLow_q | holdLow_q;
      sdaOut    <= 1'b0;
      sdaOe     <= sdaLow_q;
      serialIrq <= irq_q;
      regRdata  <= 8'h00;
      if (regRd) begin
        case (regAddr)
          `OFF_CTRL_ONE: begin
            regRdata[`BIT_CLK_HOLD] <= clockHold_q;
            regRdata[`BIT_OVERFLOW] <= overflow_q;
            regRdata[`BIT_WRITE_COLLISION_FLAG]     <= write_collision_flag_q;
          end
          `OFF_CTRL_TWO: begin
            regRdata[`BIT_START_REQ] <= startReq_q;
            regRdata[`BIT_STOP_REQ]  <= stopReq_q;
            regRdata[`BIT_RCV_REQ]   <= rcvReq_q;
            regRdata[`BIT_ACK_REQ]   <= ackReq_q;
            regRdata[`BIT_ACK_DATA]  <= ackData_q;
            regRdata[`BIT_ACK_RECV]  <= ackRecv_q;
          end
          `OFF_STATUS: begin
            regRdata[`BIT_BUF_FULL] <= bufFull_q;
            regRdata[`BIT_BUSY]     <= !idle;
            regRdata[`BIT_STOP_DET] <= stopDet_q;
          end
          `OFF_BUFFER: begin
            regRdata <= buffer_q;
          end
          `OFF_BAUD: begin
            regRdata <= baudReload_q;
          end
          `OFF_IRQ: begin
            regRdata[`BIT_IRQ] <= irq_q;
          end
          default: begin
            regRdata <= 8'h00;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== i2c_rx_asserts.sv
/* Port checker for the two-wire receive controller.
   Assumes a baud reload of 3 or more and requests written only while idle. */
`timescale 1ns/1ps
`default_nettype none
module i2c_rx_asserts (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  // Bus lines and flag
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       serialIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Grabbing a high line would cut another master's high time
  chk_hold_wait: assert property (regWr && regAddr == 3'h0 && !regWdata[4] && sclIn |=> !sclOe [*4])
    else $error("hold pulled a high clock");
  chk_rd_clear: assert property ((regRd && regAddr == 3'h3) ##2 (regRd && regAddr == 3'h2) |=> !regRdata[0])
    else $error("buffer read left full set");
  chk_ack_low: assert property (regWr && regAddr == 3'h1 && regWdata[5:4] == 2'b01 |-> ##[1:4] (sdaOe && sclOe))
    else $error("ack not driven low");
  chk_nack_free: assert property (regWr && regAddr == 3'h1 && regWdata[5:4] == 2'b11 |=> (!sdaOe && sclOe) [*4])
    else $error("nack drove data low");
  chk_stop_sda: assert property (regWr && regAddr == 3'h1 && regWdata[2] && !sdaOe && !sclIn |-> ##[1:4] sdaOe)
    else $error("stop did not pull data");
  chk_stop_irq: assert property ($fell(sdaOe) && !sclOe && sclIn |-> ##[1:40] serialIrq)
    else $error("stop end without flag");
  // Every event but the stop leaves SCL held; software needs cycles to react
  chk_held_low: assert property ($rose(serialIrq) && sclOe |-> sclOe [*4])
    else $error("clock not held after event");
  // Open-drain pins only ever pull low
  chk_pins_low: assert property (!sclOut && !sdaOut)
    else $error("pin value not low");
  chk_event_irq: assert property (
    regWr && regAddr == 3'h1 && (regWdata & 8'h1D) != 8'h00 && !serialIrq |-> ##[1:400] serialIrq)
    else $error("request never completed");
  chk_addr_start: assert property (regWr && regAddr == 3'h3 && regWdata[7] && sdaOe |-> ##[1:4] !sdaOe)
    else $error("address did not start");
endmodule
bind i2c_master_rx_ack_stop i2c_rx_asserts i2c_rx_asserts_i (.clk, .rstn, .regAddr, .regWdata, .regWr, .regRd,
  .regRdata, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe, .serialIrq);
`default_nettype wire

// ===== i2c_rx_consts.vh
/*
 Register offsets, field positions and reset values of the two-wire
 master receive, acknowledge and stop block.
 Assumes it is included by its bare name from each design file.
*/
`ifndef I2C_RX_CONSTS_VH
`define I2C_RX_CONSTS_VH

// Register offsets on the 3-bit register port
`define OFF_CTRL_ONE    3'h0
`define OFF_CTRL_TWO    3'h1
`define OFF_STATUS      3'h2
`define OFF_BUFFER      3'h3
`define OFF_BAUD        3'h4
`define OFF_IRQ         3'h5

// Control register one fields
`define BIT_CLK_HOLD    4
`define BIT_OVERFLOW    6
`define BIT_WRITE_COLLISION_FLAG        7

// Control register two fields
`define BIT_START_REQ   0
`define BIT_STOP_REQ    2
`define BIT_RCV_REQ     3
`define BIT_ACK_REQ     4
`define BIT_ACK_DATA    5
`define BIT_ACK_RECV    6

// Status register fields
`define BIT_BUF_FULL    0
`define BIT_BUSY        2
`define BIT_STOP_DET    4

// Interrupt flag register field
`define BIT_IRQ         0

// Reset values
`define RST_BAUD        8'h09
`define RST_CLK_HOLD    1'b1

// Bit counter values at the last data bit and at the acknowledge bit
`define LAST_RX_BIT     4'h7
`define ACK_BIT_INDEX   4'h8

`endif

// ===== i2c_slave_model.sv
/* Behavioural bus slave: acks the address, then sends txByte per byte.
   Assumes open-drain lines with pull-ups resolved by the bench. */
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Resolved lines
  input  wire logic       sclLine,
  input  wire logic       sdaLine,
  // Bench controls
  input  wire logic       stretchEn,
  input  wire logic [7:0] txByte,
  // Pulls, high pulls low
  output var  logic       sclHold,
  output wire logic       sdaHold
);
  logic       sclQ;
  logic       sdaQ;
  logic       active;
  logic       inData;
  logic [3:0] cnt;
  logic [2:0] holdCnt;
  // Address not decoded: only one slave on this bus
  assign sdaHold = active && (inData ? (cnt != 4'h8 && !txByte[3'h7 - cnt[2:0]]) : cnt == 4'h8);
  assign sclHold = (holdCnt != 3'h0);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      active <= 1'b0;
      inData <= 1'b0;
      cnt <= 4'hF;
      holdCnt <= 3'h0;
    end else begin
      sclQ <= sclLine;
      sdaQ <= sdaLine;
      if (sclLine && sdaQ && !sdaLine) begin
        active <= 1'b1;
        inData <= 1'b0;
        cnt <= 4'hF;
      end else if (sclLine && !sdaQ && sdaLine) begin
        active <= 1'b0;
      end else if (active && sclQ && !sclLine) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        inData <= inData || cnt == 4'h8;
        holdCnt <= stretchEn ? 3'h6 : 3'h0;
      end else if (active && inData && cnt == 4'h8 && !sclQ && sclLine && sdaLine) begin
        // Master refused more data: let go so a stop can follow
        active <= 1'b0;
      end else if (holdCnt != 3'h0) begin
        holdCnt <= holdCnt - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== pin_sync.v
/*
 Two-flop synchroniser for the sampled clock and data bus lines.
 Assumes the line levels arrive asynchronously from the pins.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  // Clock and reset
  input  wire       clk,
  input  wire       rstn,
  // Raw pin levels
  input  wire       sclPin,
  input  wire       sdaPin,
  // Synchronised levels
  output wire       sclSync,
  output wire       sdaSync
);

  reg [1:0] meta_q;
  reg [1:0] sync_q;

  // Idle bus reads high, so reset to high
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end else begin
      meta_q <= {sclPin, sdaPin};
      sync_q <= meta_q;
    end
  end

  assign sclSync = sync_q[1];
  assign sdaSync = sync_q[0];

endmodule
`default_nettype wire

// ===== tb.sv
/* Bench: register tasks, read-result queue, one slave model.
   Assumes read data stands one cycle after the strobe. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic       rdSeen = 1'b0;
  logic       tbScl = 1'b0;
  logic       stretchEn = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic [7:0] regRdata;
  logic       sclOe, sdaOe, serialIrq, sclHold, sdaHold;
  logic [7:0] expQ[$];
  int         miscompares = 0;
  int         nCompared = 0;
  int         i;
  wire        sclLine = !(sclOe || sclHold || tbScl);
  wire        sdaLine = !(sdaOe || sdaHold);
  i2c_master_rx_ack_stop i2c_master_rx_ack_stop_i (.clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .sclIn(sclLine), .sclOut(), .sclOe, .sdaIn(sdaLine), .sdaOut(), .sdaOe, .serialIrq);
  i2c_slave_model i2c_slave_model_i (.clk, .rstn, .sclLine, .sdaLine, .stretchEn, .txByte, .sclHold, .sdaHold);
  initial forever #12.5 clk = ~clk;
  task check(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    begin
      nCompared++;
      if (seen !== exp) begin
        miscompares++;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    begin
      @(posedge clk);
      expQ.push_back(e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
    end
  endtask
  task wait_irq;
    int n;
    begin
      n = 0;
      while (serialIrq !== 1'b1 && n < 800) begin
        @(posedge clk);
        n++;
      end
      check({7'h00, serialIrq}, 8'h01, "serialIrq");
      rd(3'h5, 8'h01);
      wr(3'h5, 8'h00);
    end
  endtask
  // Read data stand one cycle only, so compare in that cycle
  always @(posedge clk) begin
    if (rdSeen === 1'b1)
      check(regRdata, expQ.pop_front(), "regRdata");
    rdSeen <= regRd;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run;
  end
  initial begin
    void'($urandom(30));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(3'h4, 8'h09);
    rd(3'h0, 8'h10);
    rd(3'h6, 8'h00);
    wr(3'h4, 8'h03);
    wr(3'h0, 8'h00);
    repeat (8) @(posedge clk);
    check({7'h00, sclOe}, 8'h00, "sclOe");
    tbScl <= 1'b1;
    repeat (6) @(posedge clk);
    tbScl <= 1'b0;
    repeat (6) @(posedge clk);
    check({7'h00, sclOe}, 8'h01, "sclOe");
    wr(3'h0, 8'h10);
    repeat (6) @(posedge clk);
    check({7'h00, sclOe}, 8'h00, "sclOe");
    wr(3'h1, 8'h01);
    wait_irq;
    wr(3'h3, 8'hA1);
    wait_irq;
    rd(3'h1, 8'h00);
    for (i = 0; i < 3; i++) begin
      txByte <= 8'($urandom);
      stretchEn <= i[0];
      wr(3'h1, 8'h08);
      wr(3'h1, 8'h08);
      wr(3'h3, 8'h7F);
      rd(3'h2, (i == 2) ? 8'h05 : 8'h04);
      wait_irq;
      rd(3'h2, 8'h01);
      rd(3'h0, (i == 2) ? 8'hD0 : 8'h90);
      wr(3'h0, 8'h10);
      // Middle byte left unread so the last one overflows
      if (i != 1) begin
        rd(3'h3, txByte);
        rd(3'h2, 8'h00);
      end
      wr(3'h1, (i == 2) ? 8'h30 : 8'h10);
      wr(3'h3, 8'h7F);
      // Receive request while acknowledging must be dropped
      wr(3'h1, 8'h08);
      wait_irq;
      rd(3'h0, 8'h90);
      rd(3'h1, 8'h00);
      wr(3'h0, 8'h10);
    end
    wr(3'h1, 8'h04);
    wr(3'h3, 8'h7F);
    wait_irq;
    rd(3'h2, 8'h10);
    rd(3'h0, 8'h90);
    check({6'h00, sclOe, sdaOe}, 8'h00, "bus lines");
    // Address with no start: the slave stays idle, so no acknowledge
    wr(3'h3, 8'hA1);
    wait_irq;
    rd(3'h1, 8'h40);
    repeat (4) @(posedge clk);
    complete_run;
  end
endmodule
`default_nettype wire
